// File: core/liu_cfg_pkg.sv
// Constants, types and field layout of the line interface config bank
package liu_cfg_pkg;

    // =========================================================
    // Geometry
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;
    localparam int CH_W = 2;
    localparam int UI_W = 2;
    localparam int SAMP_W = 4;
    localparam int AMP_W = 7;
    localparam int SCALE_W = 6;
    localparam int TPL_AW = CH_W + UI_W + SAMP_W;

    // =========================================================
    // Register indices within one channel (byte address = 4 x index)
    localparam logic [5:0] IDX_SCALE = 6'h04;
    localparam logic [5:0] IDX_ACCESS = 6'h05;
    localparam logic [5:0] IDX_DATA = 6'h06;
    localparam logic [5:0] IDX_RXCTL = 6'h07;
    localparam logic [7:0] CH_STRIDE = 8'h40;

    // =========================================================
    // Field positions
    localparam int TRIG_BIT = 7;
    localparam int DIR_BIT = 6;
    localparam int UI_LSB = 4;
    localparam int SAMP_LSB = 0;
    localparam int RX_OFF_BIT = 4;
    localparam int RX_INV_BIT = 3;
    localparam int RX_EDGE_BIT = 2;
    localparam int RX_MD_LSB = 0;

    // =========================================================
    // Reset and recommended values
    localparam logic [5:0] SCALE_RST = 6'h21;
    localparam logic [5:0] SCALE_T1J1 = 6'h36;
    localparam logic [5:0] SCALE_E1 = 6'h21;
    localparam int STEP_T1J1_PCT = 2;
    localparam int STEP_E1_PCT = 3;
    localparam logic [6:0] ACCESS_RST = 7'h00;
    localparam logic [6:0] DATA_RST = 7'h00;
    localparam logic [4:0] RXCTL_RST = 5'h00;

    // =========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_HDB3_B8ZS = 2'b00,
        MODE_AMI = 2'b01,
        MODE_DUAL_NRZ = 2'b10,
        MODE_SLICER = 2'b11
    } rx_mode_t;

    typedef enum logic [1:0] {
        TPL_IDLE = 2'b01,
        TPL_RUN = 2'b10
    } tpl_state_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_SCALE = 3'h1,
        SEL_ACCESS = 3'h2,
        SEL_DATA = 3'h3,
        SEL_RXCTL = 3'h4
    } reg_sel_t;

    typedef struct packed {
        logic power_down;
        logic polarity_invert;
        logic clock_falling;
        rx_mode_t decode_mode;
    } rx_cfg_t;

    typedef struct packed {
        logic decoded;
        logic retimed_pos;
        logic retimed_neg;
        logic slicer_pos;
        logic slicer_neg;
        logic recovered_clock;
    } rx_line_t;

    typedef struct packed {
        logic single_rail;
        logic positive_rail;
        logic negative_rail;
    } rx_out_t;

endpackage : liu_cfg_pkg

// File: core/rx_output_stage.sv
// Receive output selector: mode, polarity and clock edge for one channel
module rx_output_stage
    import liu_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input liu_cfg_pkg::rx_cfg_t cfg,
    input liu_cfg_pkg::rx_line_t line,
    output liu_cfg_pkg::rx_out_t out_reg
);
    import liu_cfg_pkg::*;

    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [5:0] stable_reg;
    logic clk_prev_reg;
    rx_line_t st;
    logic clk_edge;
    logic inv;

    // =========================================================
    // Input synchroniser, change accepted when stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            sync3_reg <= 6'h00;
            stable_reg <= 6'h00;
        end else begin
            sync1_reg <= line;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            stable_reg <= (sync2_reg & sync3_reg)
                | (stable_reg & (sync2_reg ^ sync3_reg));
        end
    end

    // Previous recovered clock level for edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= st.recovered_clock;
        end
    end

    assign st = rx_line_t'(stable_reg);
    assign inv = cfg.polarity_invert;
    assign clk_edge = cfg.clock_falling ?
        (clk_prev_reg & ~st.recovered_clock) :
        (~clk_prev_reg & st.recovered_clock);

    // =========================================================
    // Output selection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_reg <= '0;
        end else if (cfg.power_down) begin
            out_reg <= '0;
        end else begin
            case (cfg.decode_mode)
                MODE_SLICER: begin
                    out_reg.single_rail <= 1'b0;
                    out_reg.positive_rail <= st.slicer_pos ^ inv;
                    out_reg.negative_rail <= st.slicer_neg ^ inv;
                end
                MODE_DUAL_NRZ: begin
                    if (clk_edge) begin
                        out_reg.single_rail <= 1'b0;
                        out_reg.positive_rail <= st.retimed_pos ^ inv;
                        out_reg.negative_rail <= st.retimed_neg ^ inv;
                    end
                end
                default: begin
                    if (clk_edge) begin
                        out_reg.single_rail <= st.decoded ^ inv;
                        out_reg.positive_rail <= 1'b0;
                        out_reg.negative_rail <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule : rx_output_stage

// File: core/liu_tx_template_rx_config_regs.sv
// Per-channel transmit template and receive path configuration registers
module liu_tx_template_rx_config_regs
    import liu_cfg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [liu_cfg_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [liu_cfg_pkg::NUM_CH-1:0][5:0] AMPLITUDE_SCALE,
    input wire logic [liu_cfg_pkg::CH_W-1:0] SHAPER_CHANNEL,
    input wire logic [liu_cfg_pkg::UI_W-1:0] SHAPER_INTERVAL,
    input wire logic [liu_cfg_pkg::SAMP_W-1:0] SHAPER_SAMPLE,
    output logic [liu_cfg_pkg::AMP_W-1:0] SHAPER_AMPLITUDE,
    output liu_cfg_pkg::rx_cfg_t [liu_cfg_pkg::NUM_CH-1:0] RX_CONFIG,
    input liu_cfg_pkg::rx_line_t [liu_cfg_pkg::NUM_CH-1:0] RX_LINE,
    output liu_cfg_pkg::rx_out_t [liu_cfg_pkg::NUM_CH-1:0] RX_OUT
);
    import liu_cfg_pkg::*;

    // =========================================================
    // Register state
    logic [SCALE_W-1:0] scale_reg [NUM_CH];
    logic [6:0] access_reg [NUM_CH];
    logic [AMP_W-1:0] data_reg [NUM_CH];
    logic [4:0] rxctl_reg [NUM_CH];
    logic [AMP_W-1:0] tpl_ram [2**TPL_AW];

    tpl_state_t state_reg;
    tpl_state_t state_next;
    logic [CH_W-1:0] op_ch_reg;
    logic op_read_reg;
    logic [TPL_AW-1:0] op_addr_reg;

    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [AMP_W-1:0] shaper_amp_reg;
    rx_cfg_t [NUM_CH-1:0] rx_cfg_reg;

    logic [IDX_W-1:0] idx;
    logic [CH_W-1:0] ch;
    reg_sel_t sel;
    logic setup;
    logic wr_commit;
    logic trig_write;
    logic [7:0] wbyte;

    // =========================================================
    // Address decode
    // channel copies
    function automatic reg_sel_t decode(input logic [IDX_W-1:0] i);
        logic [5:0] r;
        r = i[5:0];
        if (r == IDX_SCALE) begin
            decode = SEL_SCALE;
        end else if (r == IDX_ACCESS) begin
            decode = SEL_ACCESS;
        end else if (r == IDX_DATA) begin
            decode = SEL_DATA;
        end else if (r == IDX_RXCTL) begin
            decode = SEL_RXCTL;
        end else begin
            decode = SEL_NONE;
        end
    endfunction : decode

    assign idx = PADDR[ADDR_W-1:2];
    assign ch = idx[IDX_W-1:IDX_W-CH_W];
    assign sel = decode(idx);
    assign setup = PSEL & ~PENABLE;
    assign wr_commit = PSEL & PENABLE & PWRITE & pready_reg;
    assign wbyte = PWDATA[7:0];
    assign trig_write = wr_commit & (sel == SEL_ACCESS) & wbyte[TRIG_BIT]
        & (state_reg == TPL_IDLE);

    // Read mux of one register word
    function automatic logic [31:0] read_word(input logic [CH_W-1:0] c,
                                              input reg_sel_t s);
        read_word = 32'h0000_0000;
        case (s)
            SEL_SCALE: read_word[SCALE_W-1:0] = scale_reg[c];
            SEL_ACCESS: begin
                read_word[6:0] = access_reg[c];
                read_word[TRIG_BIT] = (state_reg == TPL_RUN)
                    && (op_ch_reg == c);
            end
            SEL_DATA: read_word[AMP_W-1:0] = data_reg[c];
            SEL_RXCTL: read_word[4:0] = rxctl_reg[c];
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // =========================================================
    // APB handshake: ready in first access cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup & ~pready_reg;
            if (setup) begin
                pslverr_reg <= (sel == SEL_NONE);
                prdata_reg <= PWRITE ? 32'h0000_0000 : read_word(ch, sel);
            end else if (pready_reg) begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // =========================================================
    // Per-channel register copies
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // Scale register
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    scale_reg[g] <= SCALE_RST;
                end else if (wr_commit && sel == SEL_SCALE && ch == g) begin
                    scale_reg[g] <= wbyte[SCALE_W-1:0];
                end
            end

            // Access control: direction, interval, sample
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    access_reg[g] <= ACCESS_RST;
                end else if (wr_commit && sel == SEL_ACCESS && ch == g) begin
                    access_reg[g] <= wbyte[6:0];
                end
            end

            // Template data, loaded by software or by a read access
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    data_reg[g] <= DATA_RST;
                end else if (state_reg == TPL_RUN && op_read_reg
                             && op_ch_reg == g) begin
                    data_reg[g] <= tpl_ram[op_addr_reg];
                end else if (wr_commit && sel == SEL_DATA && ch == g) begin
                    data_reg[g] <= wbyte[AMP_W-1:0];
                end
            end

            // Receive control
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    rxctl_reg[g] <= RXCTL_RST;
                end else if (wr_commit && sel == SEL_RXCTL && ch == g) begin
                    rxctl_reg[g] <= wbyte[4:0];
                end
            end

            // Registered config towards receiver and outputs
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    rx_cfg_reg[g] <= '0;
                    AMPLITUDE_SCALE[g] <= SCALE_RST;
                end else begin
                    rx_cfg_reg[g].power_down <= rxctl_reg[g][RX_OFF_BIT];
                    rx_cfg_reg[g].polarity_invert <=
                        rxctl_reg[g][RX_INV_BIT];
                    rx_cfg_reg[g].clock_falling <=
                        rxctl_reg[g][RX_EDGE_BIT];
                    rx_cfg_reg[g].decode_mode <=
                        rx_mode_t'(rxctl_reg[g][RX_MD_LSB +: 2]);
                    AMPLITUDE_SCALE[g] <= scale_reg[g];
                end
            end

            // Receive output stage
            rx_output_stage u_rx (
                .clk(SYS_CLK),
                .rst_b(RST_B),
                .cfg(rx_cfg_reg[g]),
                .line(RX_LINE[g]),
                .out_reg(RX_OUT[g])
            );
        end
    endgenerate

    // =========================================================
    // Indirect template access engine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TPL_IDLE: begin
                if (trig_write) begin
                    state_next = TPL_RUN;
                end
            end
            TPL_RUN: begin
                state_next = TPL_IDLE;
            end
            default: state_next = TPL_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= TPL_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operation capture at trigger write
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_ch_reg <= '0;
            op_read_reg <= 1'b0;
            op_addr_reg <= '0;
        end else if (trig_write) begin
            op_ch_reg <= ch;
            op_read_reg <= wbyte[DIR_BIT];
            op_addr_reg <= {ch, wbyte[UI_LSB +: UI_W],
                            wbyte[SAMP_LSB +: SAMP_W]};
        end
    end

    // Template RAM write port
    always_ff @(posedge SYS_CLK) begin
        if (state_reg == TPL_RUN && !op_read_reg) begin
            tpl_ram[op_addr_reg] <= data_reg[op_ch_reg];
        end
    end

    // Shaper read port
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            shaper_amp_reg <= '0;
        end else begin
            shaper_amp_reg <= tpl_ram[{SHAPER_CHANNEL, SHAPER_INTERVAL,
                                       SHAPER_SAMPLE}];
        end
    end

    // =========================================================
    // Outputs
    assign PREADY = pready_reg;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg;
    assign SHAPER_AMPLITUDE = shaper_amp_reg;
    assign RX_CONFIG = rx_cfg_reg;

endmodule : liu_tx_template_rx_config_regs

// File: testbench/liu_cfg_assertions.sv
// Checker of bus answers, register copies and receive outputs
module liu_cfg_checker
    import liu_cfg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [liu_cfg_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [liu_cfg_pkg::NUM_CH-1:0][5:0] AMPLITUDE_SCALE,
    input liu_cfg_pkg::rx_cfg_t [liu_cfg_pkg::NUM_CH-1:0] RX_CONFIG,
    input liu_cfg_pkg::rx_out_t [liu_cfg_pkg::NUM_CH-1:0] RX_OUT
);
    // ==========================================
    // Helpers
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    logic commit;
    logic [2:0] since_trig;
    // Write taking effect at this edge
    assign commit = PSEL && PENABLE && PREADY && PWRITE;
    // Cycles since the last template trigger, saturating
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B)
            since_trig <= 3'h7;
        else if (commit && PADDR[7:0] == 8'h14 && PWDATA[7])
            since_trig <= 3'h0;
        else if (since_trig != 3'h7)
            since_trig <= since_trig + 3'h1;
    end
    // ==========================================
    // Properties
    property p_no_wait;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    property p_err_map;
        PREADY |-> PSLVERR ==
            !(PADDR[7:0] inside {8'h10, 8'h14, 8'h18, 8'h1C});
    endproperty
    property p_rd_zero;
        PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0
            && (!PSLVERR || PRDATA == 32'h0);
    endproperty
    property p_scale_copy;
        commit && PADDR[7:0] == 8'h10 |=> ##1
            AMPLITUDE_SCALE[$past(PADDR[9:8], 2)] == $past(PWDATA[5:0], 2);
    endproperty
    property p_rx_copy;
        commit && PADDR[7:0] == 8'h1C |=> ##1
            RX_CONFIG[$past(PADDR[9:8], 2)] == $past(PWDATA[4:0], 2);
    endproperty
    property p_reset_vals;
        $rose(RST_B) |-> AMPLITUDE_SCALE == {4{6'h21}} && RX_CONFIG == '0;
    endproperty
    property p_pdown;
        RX_CONFIG[0].power_down [*3] |-> RX_OUT[0] == 3'h0;
    endproperty
    // Busy may show only to a read whose setup falls in the run cycle
    property p_trig_done;
        PREADY && !PWRITE && PADDR[7:0] == 8'h14 && since_trig > 3'h1
            |-> !PRDATA[7];
    endproperty
    // ==========================================
    // Assertions
    a_no_wait: assert property (p_no_wait)
        else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    a_err_map: assert property (p_err_map)
        else $error("error flag does not match address");
    a_rd_zero: assert property (p_rd_zero)
        else $error("reserved read bits not zero");
    a_scale_copy: assert property (p_scale_copy)
        else $error("scale output not updated");
    a_rx_copy: assert property (p_rx_copy)
        else $error("receive config output not updated");
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong outputs after reset");
    a_pdown: assert property (p_pdown)
        else $error("receive outputs active in power down");
    a_trig_done: assert property (p_trig_done)
        else $error("trigger bit still set");
    c_trigger: cover property (commit && PADDR[7:0] == 8'h14 && PWDATA[7]);
    c_error: cover property (PREADY && PSLVERR);
    c_slicer: cover property (RX_CONFIG[0].decode_mode == MODE_SLICER
        && RX_OUT[0].positive_rail);
endmodule : liu_cfg_checker

bind liu_tx_template_rx_config_regs liu_cfg_checker i_liu_cfg_checker (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .AMPLITUDE_SCALE(AMPLITUDE_SCALE),
    .RX_CONFIG(RX_CONFIG), .RX_OUT(RX_OUT));

// File: testbench/liu_tx_template_rx_config_regs_tb.sv
// Self-checking bench of the line interface config bank
module liu_tx_template_rx_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import liu_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0][5:0] amp_scale;
    logic [1:0] shp_ch = 2'h0;
    logic [1:0] shp_ui = 2'h0;
    logic [3:0] shp_smp = 4'h0;
    logic [6:0] shp_amp;
    rx_cfg_t [3:0] rx_cfg;
    rx_line_t [3:0] rx_line = '0;
    rx_out_t [3:0] rx_out;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int c, i, m;
    logic [31:0] rnd, v, u;
    logic [5:0] a;
    logic [6:0] amp;
    logic [4:0] cfg;
    logic [5:0] scale_m [4];
    logic [4:0] rx_m [4];
    logic [6:0] tpl_m [256];

    liu_tx_template_rx_config_regs i_liu_tx_template_rx_config_regs (
        .SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .AMPLITUDE_SCALE(amp_scale),
        .SHAPER_CHANNEL(shp_ch), .SHAPER_INTERVAL(shp_ui),
        .SHAPER_SAMPLE(shp_smp), .SHAPER_AMPLITUDE(shp_amp),
        .RX_CONFIG(rx_cfg), .RX_LINE(rx_line), .RX_OUT(rx_out));

    // ==========================================
    // Clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Expected receive outputs from config and line value
    function automatic logic [2:0] exp_out(input logic [4:0] f,
            input logic [31:0] d);
        logic [2:0] e;
        e = 3'h0;
        case (f[1:0])
            2'h0, 2'h1: e[2] = d[5] ^ f[3];
            2'h2: e[1:0] = d[4:3] ^ {2{f[3]}};
            default: e[1:0] = d[2:1] ^ {2{f[3]}};
        endcase
        return f[4] ? 3'h0 : e;
    endfunction : exp_out
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    // One APB transfer; error flag expected only off the map
    task automatic xfer(input bit wr, input int ch, input int idx,
            input logic [31:0] d, input logic [31:0] x);
        logic [31:0] q;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ch[1:0], idx[5:0], 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        chk({31'h0, pslverr}, {31'h0, idx < 4 || idx > 7});
        if (!wr)
            chk(q, x);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // ==========================================
    // Main sequence
    initial begin
        rnd = 32'hBB86;
        v = 32'h0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // reset values and unmapped places per channel
        for (c = 0; c < 4; c++) begin
            xfer(1'b0, c, 4, 32'h0, 32'h21);
            xfer(1'b0, c, 5, 32'h0, 32'h0);
            xfer(1'b1, c, 8, 32'hFF, 32'h0);
            xfer(1'b0, c, 7, 32'h0, 32'h0);
            xfer(1'b0, c, 3, 32'h0, 32'h0);
        end
        chk(32'(amp_scale), 32'h00861861);
        chk(32'(rx_cfg), 32'h0);
        $display("reset test done");
        for (i = 0; i < 12; i++) begin
            v = (i < 8) ? rnd : (i < 10) ? 32'h1036 : 32'h0821;
            rnd = lfsr(rnd);
            c = i % 4;
            scale_m[c] = v[5:0];
            rx_m[c] = v[12:8];
            xfer(1'b1, c, 4, v, 32'h0);
            xfer(1'b1, c, 7, v >> 8, 32'h0);
        end
        for (c = 0; c < 4; c++) begin
            xfer(1'b0, c, 4, 32'h0, 32'(scale_m[c]));
            xfer(1'b0, c, 7, 32'h0, 32'(rx_m[c]));
            chk(32'(amp_scale[c]), 32'(scale_m[c]));
            chk(32'(rx_cfg[c]), 32'(rx_m[c]));
        end
        $display("register test done");
        // template write, shaper read, indirect read back
        for (i = 0; i < 10; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : rnd;
            rnd = lfsr(rnd);
            c = v[9:8];
            a = v[5:0];
            amp = v[22:16];
            tpl_m[{v[9:8], a}] = amp;
            xfer(1'b1, c, 6, 32'(amp), 32'h0);
            xfer(1'b1, c, 5, {24'h0, 2'b10, a}, 32'h0);
            xfer(1'b0, c, 5, 32'h0, 32'(a));
            shp_ch <= v[9:8];
            shp_ui <= a[5:4];
            shp_smp <= a[3:0];
            repeat (2) @(posedge clk);
            chk(32'(shp_amp), 32'(tpl_m[{v[9:8], a}]));
            xfer(1'b1, c, 6, {25'h0, ~amp}, 32'h0);
            xfer(1'b1, c, 5, {24'h0, 2'b11, a}, 32'h0);
            xfer(1'b0, c, 6, 32'h0, 32'(tpl_m[{v[9:8], a}]));
        end
        $display("template test done");
        // every mode and polarity, power down, falling edge
        for (m = 0; m < 11; m++) begin
            u = v;
            v = rnd;
            rnd = lfsr(rnd);
            cfg = (m > 8) ? 5'h06 : (m == 8) ? 5'h1B
                : {1'b0, m[2], 1'b0, m[1:0]};
            xfer(1'b1, 0, 7, 32'(cfg), 32'h0);
            repeat (4) @(posedge clk);
            rx_line <= {4{v[5:1], 1'b1}};
            repeat (8) @(posedge clk);
            if (!cfg[2])
                chk(32'(rx_out[0]), 32'(exp_out(cfg, v)));
            else if (m == 10)
                chk(32'(rx_out[0]), 32'(exp_out(cfg, u)));
            rx_line <= {4{v[5:1], 1'b0}};
            repeat (8) @(posedge clk);
            chk(32'(rx_out[0]), 32'(exp_out(cfg, v)));
        end
        $display("receive test done");
        wrap_up();
    end
endmodule : liu_tx_template_rx_config_regs_tb
